/* File: include/pfcs_pkg.sv */
package pfcs_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam int PFCS_ADDR_W = 12;
  localparam logic [11:0] PFCS_OFS_FLOW_CTRL = 12'h01a0;
  localparam logic [11:0] PFCS_OFS_STRAP_SHADOW = 12'h01ac;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int PFCS_BIT_MANUAL = 0;
  localparam int PFCS_BIT_TX_EN = 1;
  localparam int PFCS_BIT_RX_EN = 2;
  localparam int PFCS_BIT_TX_CUR = 3;
  localparam int PFCS_BIT_RX_CUR = 4;
  localparam int PFCS_BIT_DUP_CUR = 5;
  localparam int PFCS_BIT_BP_EN = 6;
  // ************************************************************
  // reset values before straps are caught
  // ************************************************************
  localparam logic PFCS_RST_BIT = 1'b0;
  localparam logic [1:0] PFCS_RST_STATE = 2'h0;
endpackage : pfcs_pkg

/* File: rtl/pfcs_sync.sv */
`timescale 1ns/1ps
module pfcs_sync
  import pfcs_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;

  always_comb
  begin
    next_stage1 = i_async;
    next_stage2 = stage1;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign o_sync = stage2;
endmodule : pfcs_sync

/* File: rtl/pfcs_resolve.sv */
`timescale 1ns/1ps
module pfcs_resolve
  import pfcs_pkg::*;
(
  input wire logic i_manual,
  input wire logic i_rx_en,
  input wire logic i_tx_en,
  input wire logic i_an_enable,
  input wire logic i_an_rx_pause,
  input wire logic i_an_tx_pause,
  input wire logic i_half_duplex,
  output logic o_rx_pause,
  output logic o_tx_pause
);
  // ************************************************************
  // choice between written bits and negotiated result
  // ************************************************************
  always_comb
  begin
    if (i_half_duplex)
    begin
      // pause frames only exist in full duplex
      o_rx_pause = 1'b0;
      o_tx_pause = 1'b0;
    end
    else if (i_manual || !i_an_enable)
    begin
      o_rx_pause = i_rx_en; // R8 R9
      o_tx_pause = i_tx_en; // R8 R9
    end
    else
    begin
      o_rx_pause = i_an_rx_pause; // R7 R13
      o_tx_pause = i_an_tx_pause; // R7 R13
    end
  end
endmodule : pfcs_resolve

/* File: rtl/pfcs_top.sv */
`timescale 1ns/1ps
// What this block does
// R1: bit 6 written 1 enables half-duplex backpressure, 0 disables it.
// R2: bit 5 reads duplex in effect, 0 full, 1 half.
// R3: bit 4 reads whether receive pause is currently active.
// R4: bit 3 reads whether transmit pause is currently active.
// R5: bit 2 enables pause detection when manual or negotiation off.
// R6: bit 1 enables pause generation when manual or negotiation off.
// R7: manual 0 and negotiation on: negotiated result rules, bits ignored.
// R8: manual 0 and negotiation off: written pause bits apply.
// R9: manual 1: written pause bits apply in full duplex.
// R10: defaults come from straps, captured on the third clock edge after reset release.
// R11: loader rewrite of straps updates the derived fields.
// R12: writes here leave the phy advertised pause unchanged.
// R13: negotiated pause states come from phy result, shown in state bits.
module pfcs_top
  import pfcs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_backpressure_default_strap,
  input wire logic i_pause_default_strap,
  input wire logic i_manual_select_default_strap,
  input wire logic i_duplex_half_strap,
  input wire logic i_an_enable_strap,
  input wire logic i_strap_reload,
  input wire logic i_phy_an_enable,
  input wire logic i_phy_half_duplex,
  input wire logic i_phy_an_rx_pause,
  input wire logic i_phy_an_tx_pause,
  output logic o_port1_backpressure_enable,
  output logic o_port1_duplex_in_effect,
  output logic o_port1_rx_pause_in_effect,
  output logic o_port1_tx_pause_in_effect
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [9:0] pins_sync;

  pfcs_sync #(
    .WIDTH(10)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_async({i_backpressure_default_strap, i_pause_default_strap,
      i_manual_select_default_strap, i_duplex_half_strap,
      i_an_enable_strap, i_phy_an_enable, i_phy_half_duplex,
      i_phy_an_rx_pause, i_phy_an_tx_pause, i_strap_reload}),
    .o_sync(pins_sync)
  );

  logic s_bp;
  logic s_pause;
  logic s_manual;
  logic s_dup;
  logic s_an;
  logic p_an;
  logic p_half;
  logic p_rx;
  logic p_tx;
  logic s_reload;

  assign {s_bp, s_pause, s_manual, s_dup, s_an, p_an, p_half, p_rx, p_tx,
    s_reload} = pins_sync;

  // ************************************************************
  // strap capture after reset release and on loader reload
  // ************************************************************
  // sync chain needs two edges before straps are valid, so wait
  // three edges before the first capture
  logic [1:0] warm;
  logic [1:0] next_warm;
  logic reload_q;
  logic next_reload_q;
  logic loaded;
  logic next_loaded;
  logic capture;

  assign capture = (warm == 2'h2) || (s_reload && !reload_q);

  // ************************************************************
  // register fields
  // ************************************************************
  logic bp_en;
  logic rx_en;
  logic tx_en;
  logic manual;
  logic strap_dup;
  logic strap_an;
  logic next_bp_en;
  logic next_rx_en;
  logic next_tx_en;
  logic next_manual;
  logic next_strap_dup;
  logic next_strap_an;
  logic wr_fc;

  assign wr_fc = i_wr && (i_addr == PFCS_OFS_FLOW_CTRL);

  always_comb
  begin
    next_warm = (warm == 2'h3) ? warm : warm + 2'h1;
    next_reload_q = s_reload;
    next_loaded = loaded | capture;
    next_bp_en = bp_en;
    next_rx_en = rx_en;
    next_tx_en = tx_en;
    next_manual = manual;
    next_strap_dup = strap_dup;
    next_strap_an = strap_an;
    if (capture)
    begin
      next_bp_en = s_bp; // R10 R11
      next_rx_en = s_pause; // R10 R11
      next_tx_en = s_pause; // R10 R11
      next_manual = s_manual; // R10 R11
      next_strap_dup = s_dup; // R10 R11
      next_strap_an = s_an; // R10 R11
    end
    else if (wr_fc)
    begin
      // only this register changes; advertised pause lives in the phy
      next_bp_en = i_wdata[PFCS_BIT_BP_EN]; // R1 R12
      next_rx_en = i_wdata[PFCS_BIT_RX_EN]; // R5
      next_tx_en = i_wdata[PFCS_BIT_TX_EN]; // R6
      next_manual = i_wdata[PFCS_BIT_MANUAL]; // R7
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      warm <= PFCS_RST_STATE;
      reload_q <= PFCS_RST_BIT;
      loaded <= PFCS_RST_BIT;
      bp_en <= PFCS_RST_BIT;
      rx_en <= PFCS_RST_BIT;
      tx_en <= PFCS_RST_BIT;
      manual <= PFCS_RST_BIT;
      strap_dup <= PFCS_RST_BIT;
      strap_an <= PFCS_RST_BIT;
    end
    else
    begin
      warm <= next_warm;
      reload_q <= next_reload_q;
      loaded <= next_loaded;
      bp_en <= next_bp_en;
      rx_en <= next_rx_en;
      tx_en <= next_tx_en;
      manual <= next_manual;
      strap_dup <= next_strap_dup;
      strap_an <= next_strap_an;
    end
  end

  // ************************************************************
  // state in effect
  // ************************************************************
  // phy status wins once the phy reports negotiation; straps
  // stand in until then
  logic an_on;
  logic half;
  logic rx_eff;
  logic tx_eff;

  assign an_on = p_an | strap_an;
  assign half = p_an ? p_half : strap_dup; // R2

  pfcs_resolve u_resolve (
    .i_manual(manual),
    .i_rx_en(rx_en),
    .i_tx_en(tx_en),
    .i_an_enable(an_on),
    .i_an_rx_pause(p_rx),
    .i_an_tx_pause(p_tx),
    .i_half_duplex(half),
    .o_rx_pause(rx_eff),
    .o_tx_pause(tx_eff)
  );

  logic dup_q;
  logic rx_q;
  logic tx_q;
  logic next_dup_q;
  logic next_rx_q;
  logic next_tx_q;

  always_comb
  begin
    next_dup_q = loaded ? half : PFCS_RST_BIT;
    next_rx_q = loaded ? rx_eff : PFCS_RST_BIT; // R3
    next_tx_q = loaded ? tx_eff : PFCS_RST_BIT; // R4
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dup_q <= PFCS_RST_BIT;
      rx_q <= PFCS_RST_BIT;
      tx_q <= PFCS_RST_BIT;
    end
    else
    begin
      dup_q <= next_dup_q;
      rx_q <= next_rx_q;
      tx_q <= next_tx_q;
    end
  end

  assign o_port1_backpressure_enable = bp_en; // R1
  assign o_port1_duplex_in_effect = dup_q;
  assign o_port1_rx_pause_in_effect = rx_q;
  assign o_port1_tx_pause_in_effect = tx_q;

  // ************************************************************
  // read path
  // ************************************************************
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (i_rd)
    begin
      case (i_addr)
        PFCS_OFS_FLOW_CTRL:
        begin
          next_rdata[PFCS_BIT_BP_EN] = bp_en;
          next_rdata[PFCS_BIT_DUP_CUR] = dup_q; // R2
          next_rdata[PFCS_BIT_RX_CUR] = rx_q; // R3
          next_rdata[PFCS_BIT_TX_CUR] = tx_q; // R4
          next_rdata[PFCS_BIT_RX_EN] = rx_en;
          next_rdata[PFCS_BIT_TX_EN] = tx_en;
          next_rdata[PFCS_BIT_MANUAL] = manual;
        end
        PFCS_OFS_STRAP_SHADOW:
        begin
          next_rdata[0] = strap_an;
          next_rdata[1] = strap_dup;
          next_rdata[2] = loaded;
        end
        default:
        begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rdata <= 32'h0000_0000;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  assign o_rdata = rdata;

  // ************************************************************
  // checks
  // ************************************************************
  property p_bp_write;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (wr_fc && !capture) |=> (o_port1_backpressure_enable
      == $past(i_wdata[PFCS_BIT_BP_EN]));
  endproperty
  a_bp_write: assert property (p_bp_write) // R1
    else $error("backpressure enable not taken from write");

  property p_half_no_pause;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    o_port1_duplex_in_effect |-> !o_port1_tx_pause_in_effect;
  endproperty
  a_half_no_pause: assert property (p_half_no_pause) // R2
    else $error("pause active in half duplex");

  property p_rx_manual;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (loaded && manual && !half && $stable(rx_en)) |=>
      (o_port1_rx_pause_in_effect == $past(rx_en));
  endproperty
  a_rx_manual: assert property (p_rx_manual) // R9
    else $error("manual receive pause not applied");

  property p_tx_an_off;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (loaded && !an_on && !half) |=>
      (o_port1_tx_pause_in_effect == $past(tx_en));
  endproperty
  a_tx_an_off: assert property (p_tx_an_off) // R8
    else $error("written transmit pause not applied");

  property p_an_rules;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (loaded && !manual && an_on && !half) |=>
      (o_port1_rx_pause_in_effect == $past(p_rx));
  endproperty
  a_an_rules: assert property (p_an_rules) // R7
    else $error("negotiated receive pause not applied");

  property p_strap_load;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    capture |=> (manual == $past(s_manual)) && (bp_en == $past(s_bp));
  endproperty
  a_strap_load: assert property (p_strap_load) // R10
    else $error("strap defaults not loaded");

  property p_read_state;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (i_rd && i_addr == PFCS_OFS_FLOW_CTRL) |=>
      (o_rdata[PFCS_BIT_TX_CUR] == $past(tx_q));
  endproperty
  a_read_state: assert property (p_read_state) // R4
    else $error("state bit read back wrong");

  property p_read_rx_en;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (i_rd && i_addr == PFCS_OFS_FLOW_CTRL) |=>
      (o_rdata[PFCS_BIT_RX_EN] == $past(rx_en));
  endproperty
  a_read_rx_en: assert property (p_read_rx_en) // R5
    else $error("receive enable read back wrong");

  property p_cov_reload;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    loaded && capture;
  endproperty
  c_cov_reload: cover property (p_cov_reload);

  property p_cov_an;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    !manual && an_on && o_port1_rx_pause_in_effect;
  endproperty
  c_cov_an: cover property (p_cov_an);

  property p_cov_manual;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    manual && o_port1_tx_pause_in_effect;
  endproperty
  c_cov_manual: cover property (p_cov_manual);
endmodule : pfcs_top

/* File: sim/tb_port_flow_control_select.sv */
`timescale 1ns/1ps
module tb_port_flow_control_select;
  import pfcs_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic i_ref_clk, i_arst_n, i_wr, i_rd, i_strap_reload;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rd, w;
  logic s_bp, s_pause, s_man, s_half, s_an;
  logic phy_an, phy_half, phy_rx, phy_tx;
  logic o_bp, o_dup, o_rx, o_tx;
  logic [6:0] m;
  int err_total, tests_run;

  pfcs_top u_dut (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_backpressure_default_strap(s_bp),
    .i_pause_default_strap(s_pause),
    .i_manual_select_default_strap(s_man),
    .i_duplex_half_strap(s_half),
    .i_an_enable_strap(s_an),
    .i_strap_reload(i_strap_reload),
    .i_phy_an_enable(phy_an),
    .i_phy_half_duplex(phy_half),
    .i_phy_an_rx_pause(phy_rx),
    .i_phy_an_tx_pause(phy_tx),
    .o_port1_backpressure_enable(o_bp),
    .o_port1_duplex_in_effect(o_dup),
    .o_port1_rx_pause_in_effect(o_rx),
    .o_port1_tx_pause_in_effect(o_tx)
  );

  // ************************************************************
  // expectations
  // ************************************************************
  // negotiation is on if the phy reports it or the strap defaults it on
  function automatic logic [31:0] exp_word(input logic [6:0] r);
    logic half, an_on, use_bits, rx, tx;
    half = phy_an ? phy_half : s_half;
    an_on = phy_an | s_an;
    use_bits = r[PFCS_BIT_MANUAL] | ~an_on;
    // pause is full-duplex only
    rx = ~half & (use_bits ? r[PFCS_BIT_RX_EN] : phy_rx);
    tx = ~half & (use_bits ? r[PFCS_BIT_TX_EN] : phy_tx);
    exp_word = {25'h000_0000, r[PFCS_BIT_BP_EN], half, rx, tx, r[2:0]};
  endfunction : exp_word

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input string name, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", name, e, g);
      err_total++;
    end
  endtask : chk

  // strobes stay up across calls, so back-to-back cycles need no gap
  task automatic bus(input logic wr, input logic rdn, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= wr;
    i_rd <= rdn;
    i_addr <= a;
    i_wdata <= d;
  endtask : bus

  task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
    bus(1'b0, 1'b1, a, 32'h0000_0000);
    bus(1'b0, 1'b0, a, 32'h0000_0000);
    @(negedge i_ref_clk);
    v = o_rdata;
    @(negedge i_ref_clk);
    chk("rdata_idle", 32'h0000_0000, o_rdata);
  endtask : rd_reg

  task automatic settle;
    repeat (8) @(posedge i_ref_clk);
  endtask : settle

  task automatic check_all;
    logic [31:0] e;
    e = exp_word(m);
    rd_reg(PFCS_OFS_FLOW_CTRL, rd);
    chk("flow_ctrl", e, rd);
    chk("bp_out", {31'h0, e[PFCS_BIT_BP_EN]}, {31'h0, o_bp});
    chk("dup_out", {31'h0, e[PFCS_BIT_DUP_CUR]}, {31'h0, o_dup});
    chk("rx_out", {31'h0, e[PFCS_BIT_RX_CUR]}, {31'h0, o_rx});
    chk("tx_out", {31'h0, e[PFCS_BIT_TX_CUR]}, {31'h0, o_tx});
  endtask : check_all

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // ************************************************************
  // clock and watchdog
  // ************************************************************
  initial
  begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    $display("ERROR watchdog expected done seen hang");
    err_total++;
    test_done();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    err_total = 0;
    tests_run = 0;
    i_arst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 12'h000;
    i_wdata = 32'h0000_0000;
    i_strap_reload = 1'b0;
    s_bp = 1'b1;
    s_pause = 1'b1;
    s_man = 1'b0;
    s_half = 1'b0;
    s_an = 1'b0;
    phy_an = 1'b0;
    phy_half = 1'b0;
    phy_rx = 1'b0;
    phy_tx = 1'b0;
    w = $urandom(32'h3ce6);
    repeat (20) @(posedge i_ref_clk);
    chk("rst_out", 32'h0, {28'h0, o_bp, o_dup, o_rx, o_tx});
    @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    settle();
    m = {s_bp, 3'b000, s_pause, s_pause, s_man};
    check_all();
    rd_reg(PFCS_OFS_STRAP_SHADOW, rd);
    chk("strap_shadow", {29'h0, 1'b1, s_half, s_an}, rd);
    $display("test reset defaults done");

    // random writes against random phy results, a stale write first
    for (int i = 0; i < 64; i++)
    begin
      w = $urandom();
      @(posedge i_ref_clk);
      {phy_an, phy_half, phy_rx, phy_tx} <= 4'($urandom());
      bus(1'b1, 1'b0, PFCS_OFS_FLOW_CTRL, ~w);
      bus(1'b1, 1'b0, PFCS_OFS_FLOW_CTRL, w);
      bus(1'b0, 1'b0, PFCS_OFS_FLOW_CTRL, 32'h0000_0000);
      m = w[6:0];
      settle();
      check_all();
    end
    $display("test random select done");

    // neighbouring offset is not ours: reads 0, write has no effect
    bus(1'b1, 1'b0, 12'h1a4, ~{25'h0, m});
    bus(1'b0, 1'b0, 12'h1a4, 32'h0000_0000);
    rd_reg(12'h1a4, rd);
    chk("unmapped", 32'h0000_0000, rd);
    settle();
    check_all();
    $display("test unmapped done");

    // loader rewrites straps; phy negotiation off so duplex follows strap
    for (int i = 0; i < 8; i++)
    begin
      @(posedge i_ref_clk);
      phy_an <= 1'b0;
      {s_bp, s_pause, s_man, s_half, s_an} <= 5'(i * 7 + 3);
      settle();
      @(posedge i_ref_clk);
      i_strap_reload <= 1'b1;
      settle();
      @(posedge i_ref_clk);
      i_strap_reload <= 1'b0;
      settle();
      m = {s_bp, 3'b000, s_pause, s_pause, s_man};
      check_all();
      rd_reg(PFCS_OFS_STRAP_SHADOW, rd);
      chk("strap_shadow", {29'h0, 1'b1, s_half, s_an}, rd);
    end
    $display("test strap reload done");
    test_done();
  end
endmodule : tb_port_flow_control_select
